//--- write_uncorrectable_pkg.sv
/*
 * Shared constants and types for the write-uncorrectable command block:
 * register offsets, opcodes, option codes, task-file bit positions and
 * the sector-mark record.
 * Assumes a 32-bit APB master and a 50 MHz single clock domain.
 */
`default_nettype none

package write_uncorrectable_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_FEATURE    = 8'h00;
    localparam logic [7:0] OFS_COUNT      = 8'h04;
    localparam logic [7:0] OFS_LBA_LOW    = 8'h08;
    localparam logic [7:0] OFS_LBA_HIGH   = 8'h0C;
    localparam logic [7:0] OFS_CONTROL    = 8'h10;
    localparam logic [7:0] OFS_COMMAND    = 8'h14;
    localparam logic [7:0] OFS_STATUS     = 8'h18;
    localparam logic [7:0] OFS_ERROR      = 8'h1C;
    localparam logic [7:0] OFS_RESULT     = 8'h20;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h28;

    // opcodes and option codes
    localparam logic [7:0] CMD_WRITE_UNC  = 8'h45;
    localparam logic [7:0] OPT_PSEUDO     = 8'h55;
    localparam logic [7:0] OPT_FLAGGED    = 8'hAA;

    // error byte bit positions
    localparam int ERR_UNC_BIT = 6;
    localparam int ERR_IDN_BIT = 4;
    localparam int ERR_ABT_BIT = 2;

    // status byte bit positions
    localparam int STS_BSY_BIT = 7;
    localparam int STS_RDY_BIT = 6;
    localparam int STS_DSC_BIT = 4;
    localparam int STS_ERR_BIT = 0;

    // interrupt status bit positions
    localparam int IRQ_DONE_BIT  = 0;
    localparam int IRQ_ERROR_BIT = 1;

    // reset values and counts
    localparam logic [16:0] COUNT_ZERO_MEANS = 17'h10000;
    localparam logic [15:0] RECOVERY_CYCLES  = 16'h0010;
    localparam logic [7:0]  RESET_BYTE       = 8'h00;

    typedef enum logic [1:0] {
        OP_PSEUDO,
        OP_FLAGGED,
        OP_READ,
        OP_WRITE
    } op_type;

    typedef enum {
        ST_IDLE,
        ST_SCAN,
        ST_RECOVER
    } phase_type;

    typedef struct packed {
        logic        valid;
        logic        pseudo;
        logic [47:0] lba;
    } mark_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_type;

endpackage

`default_nettype wire

//--- write_uncorrectable_cmd.sv
/*
 * Task-file command engine for the write-uncorrectable command, plus the
 * read and write behaviour of marked sectors, over an APB register slave.
 * Assumes a media error flag from the drive side (asynchronous, synced
 * here) and a nonvolatile store that saves each mark record it is given.
 */
`default_nettype none

module write_uncorrectable_cmd
    import write_uncorrectable_pkg::*;
#(
    parameter int          ENTRIES   = 8,
    parameter int          LOG_BLOCK = 3,
    parameter logic [47:0] MAX_LBA   = 48'hFFFF_FFFF_FFFF
)(
    input  wire logic                       clk,        // 50 MHz clock
    input  wire logic                       rstn,       // async reset, low
    input  wire logic                       psel,       // apb select
    input  wire logic                       penable,    // apb enable
    input  wire logic                       pwrite,     // apb direction
    input  wire logic [7:0]                 paddr,      // apb byte address
    input  wire logic [31:0]                pwdata,     // apb write data
    output logic [31:0]                     prdata,     // apb read data
    output logic                            pready,     // apb ready
    output logic                            pslverr,    // unmapped address
    input  wire logic                       media_err,  // media fault, async
    output logic                            irq,        // level interrupt
    output logic                            nv_wr,      // mark save pulse
    output logic [$clog2(ENTRIES)-1:0]      nv_index,   // saved slot
    output write_uncorrectable_pkg::mark_type nv_entry  // saved record
);
    import write_uncorrectable_pkg::*;

    localparam int IW = $clog2(ENTRIES);
    localparam logic [47:0] BLOCK_MASK =
        ~((48'h1 << LOG_BLOCK) - 48'h1);

    typedef struct packed {
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
        logic                    irq;
        logic                    nv_wr;
        logic [IW-1:0]           nv_index;
        mark_type                nv_entry;
        logic                    sync1;
        logic                    sync2;
        logic [7:0]              feature;
        logic [15:0]             count;
        logic [23:0]             lba_low;
        logic [23:0]             lba_high;
        logic                    hob;
        logic [7:0]              command;
        logic [7:0]              error;
        logic                    busy;
        logic [47:0]             result;
        logic [1:0]              irq_status;
        logic [1:0]              irq_mask;
        phase_type               phase;
        op_type                  op;
        logic [47:0]             cur_lba;
        logic [16:0]             remaining;
        logic [15:0]             recover;
        mark_type [ENTRIES-1:0]  marks;
    } state_type;

    state_type s;
    state_type next_s;

    function automatic logic is_read_cmd(input logic [7:0] c);
        // dma, multiple, sector(s), verify, stream reads, with ext forms
        return c inside {8'hC8, 8'h25, 8'hC4, 8'h29, 8'h20, 8'h21,
                         8'h24, 8'h40, 8'h41, 8'h42, 8'h2A, 8'h2B};
    endfunction

    function automatic logic is_write_cmd(input logic [7:0] c);
        return c inside {8'hCA, 8'h35, 8'hC5, 8'h39, 8'h30, 8'h31,
                         8'h34, 8'h3A, 8'h3B};
    endfunction

    function automatic logic hits(input mark_type m, input logic [47:0] a);
        if (!m.valid)
            return 1'b0;
        if (m.pseudo)
            return m.lba == (a & BLOCK_MASK);
        return m.lba == a;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a inside {OFS_FEATURE, OFS_COUNT, OFS_LBA_LOW, OFS_LBA_HIGH,
                         OFS_CONTROL, OFS_COMMAND, OFS_STATUS, OFS_ERROR,
                         OFS_RESULT, OFS_IRQ_STATUS, OFS_IRQ_MASK};
    endfunction

    apb_req_type req;
    logic        setup;
    logic        access;
    logic [1:0]  events;
    logic [ENTRIES-1:0] hit_flag;
    logic [ENTRIES-1:0] hit_pseudo;
    logic [ENTRIES-1:0] same;
    logic [ENTRIES-1:0] free;
    logic [IW-1:0] hit_idx;
    logic [IW-1:0] put_idx;
    logic        put_ok;
    logic [47:0] key;

    // pseudo marks are stored block-aligned, flagged ones as given
    assign key = (s.op == OP_PSEUDO) ? (s.cur_lba & BLOCK_MASK) : s.cur_lba;

    // per-slot match vectors for the sector under scan
    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++)
        begin : slot
            assign hit_flag[g]   = hits(s.marks[g], s.cur_lba)
                                   && !s.marks[g].pseudo;
            assign hit_pseudo[g] = hits(s.marks[g], s.cur_lba)
                                   && s.marks[g].pseudo;
            assign same[g]       = s.marks[g].valid
                                   && s.marks[g].lba == key
                                   && s.marks[g].pseudo == (s.op == OP_PSEUDO);
            assign free[g]       = !s.marks[g].valid;
        end
    endgenerate

    // lowest matching slot for clearing, or reusable slot for marking
    always_comb
    begin
        hit_idx = '0;
        put_idx = '0;
        put_ok  = 1'b0;
        for (int i = ENTRIES - 1; i >= 0; i--)
        begin
            if (hit_flag[i] || hit_pseudo[i])
                hit_idx = IW'(i);
            if (free[i])
            begin
                put_idx = IW'(i);
                put_ok  = 1'b1;
            end
        end
        // an existing identical mark is reused so a range never duplicates
        for (int i = ENTRIES - 1; i >= 0; i--)
        begin
            if (same[i])
            begin
                put_idx = IW'(i);
                put_ok  = 1'b1;
            end
        end
    end

    always_comb
    begin
        next_s = s;
        req = '{psel, penable, pwrite, paddr, pwdata};
        setup  = req.psel && !req.penable;
        access = req.psel && req.penable && s.pready;
        events = 2'b00;
        next_s.pready  = 1'b0;
        next_s.pslverr = 1'b0;
        next_s.nv_wr   = 1'b0;
        next_s.sync1   = media_err;
        next_s.sync2   = s.sync1;

        // zero wait state: ready follows every setup cycle
        if (setup)
        begin
            next_s.pready  = 1'b1;
            next_s.pslverr = !mapped(req.paddr);
            next_s.prdata  = 32'h0000_0000;
            unique case (req.paddr)
                OFS_FEATURE:    next_s.prdata[7:0]  = s.feature;
                OFS_COUNT:      next_s.prdata[15:0] = s.count;
                OFS_LBA_LOW:    next_s.prdata[23:0] = s.lba_low;
                OFS_LBA_HIGH:   next_s.prdata[23:0] = s.lba_high;
                OFS_CONTROL:    next_s.prdata[0]    = s.hob;
                OFS_COMMAND:    next_s.prdata[7:0]  = s.command;
                OFS_STATUS:
                begin
                    next_s.prdata[STS_BSY_BIT] = s.busy;
                    next_s.prdata[STS_RDY_BIT] = 1'b1;
                    next_s.prdata[STS_DSC_BIT] = 1'b1;
                    next_s.prdata[STS_ERR_BIT] = |s.error;
                end
                OFS_ERROR:      next_s.prdata[7:0]  = s.error;
                OFS_RESULT:     next_s.prdata[23:0] = s.hob ?
                                    s.result[47:24] : s.result[23:0];
                OFS_IRQ_STATUS: next_s.prdata[1:0]  = s.irq_status;
                OFS_IRQ_MASK:   next_s.prdata[1:0]  = s.irq_mask;
                default:        next_s.prdata       = 32'h0000_0000;
            endcase
        end

        // task-file writes other than control and irq mask are ignored while a command runs
        if (access && req.pwrite && !s.pslverr)
        begin
            if (req.paddr == OFS_IRQ_MASK)
                next_s.irq_mask = req.pwdata[1:0];
            if (req.paddr == OFS_CONTROL)
                next_s.hob = req.pwdata[0];
            if (!s.busy)
            begin
                unique case (req.paddr)
                    OFS_FEATURE:  next_s.feature  = req.pwdata[7:0];
                    OFS_COUNT:    next_s.count    = req.pwdata[15:0];
                    OFS_LBA_LOW:  next_s.lba_low  = req.pwdata[23:0];
                    OFS_LBA_HIGH: next_s.lba_high = req.pwdata[23:0];
                    default:      next_s.command  = s.command;
                endcase
            end
            if (!s.busy && req.paddr == OFS_COMMAND)
            begin
                next_s.command   = req.pwdata[7:0];
                next_s.error     = RESET_BYTE;
                next_s.result    = '0;
                next_s.cur_lba   = {s.lba_high, s.lba_low};
                next_s.remaining = (s.count == 16'h0000) ?
                                   COUNT_ZERO_MEANS : {1'b0, s.count};
                next_s.busy      = 1'b1;
                next_s.phase     = ST_SCAN;
                if (req.pwdata[7:0] == CMD_WRITE_UNC)
                begin
                    if (s.feature == OPT_PSEUDO)
                        next_s.op = OP_PSEUDO;
                    else if (s.feature == OPT_FLAGGED)
                        next_s.op = OP_FLAGGED;
                    else
                    begin
                        next_s.error[ERR_ABT_BIT] = 1'b1;
                        next_s.busy  = 1'b0;
                        next_s.phase = ST_IDLE;
                        events = 2'b11;
                    end
                end
                else if (is_read_cmd(req.pwdata[7:0]))
                    next_s.op = OP_READ;
                else if (is_write_cmd(req.pwdata[7:0]))
                    next_s.op = OP_WRITE;
                else
                begin
                    next_s.error[ERR_ABT_BIT] = 1'b1;
                    next_s.busy  = 1'b0;
                    next_s.phase = ST_IDLE;
                    events = 2'b11;
                end
            end
        end

        // one sector per cycle, or one mark cleared per cycle on writes; the first failing sector ends the command
        unique case (s.phase)
            ST_IDLE:
                next_s.recover = RECOVERY_CYCLES;
            ST_SCAN:
            begin
                if (s.cur_lba > MAX_LBA)
                begin
                    next_s.error[ERR_IDN_BIT] = 1'b1;
                    next_s.result = s.cur_lba;
                    next_s.busy   = 1'b0;
                    next_s.phase  = ST_IDLE;
                    events = 2'b11;
                end
                else if (s.op == OP_PSEUDO || s.op == OP_FLAGGED)
                begin
                    if (!put_ok)
                    begin
                        next_s.error[ERR_ABT_BIT] = 1'b1;
                        next_s.result = s.cur_lba;
                        next_s.busy   = 1'b0;
                        next_s.phase  = ST_IDLE;
                        events = 2'b11;
                    end
                    else
                    begin
                        next_s.marks[put_idx] =
                            '{1'b1, s.op == OP_PSEUDO, key};
                        next_s.nv_wr    = 1'b1;
                        next_s.nv_index = put_idx;
                        next_s.nv_entry = '{1'b1, s.op == OP_PSEUDO, key};
                    end
                end
                else if (s.op == OP_WRITE && (|hit_flag || |hit_pseudo))
                begin
                    // clear one mark per cycle, stay on the sector
                    next_s.marks[hit_idx] = '0;
                    next_s.nv_wr    = 1'b1;
                    next_s.nv_index = hit_idx;
                    next_s.nv_entry = '0;
                end
                else if (s.sync2 || (s.op == OP_READ && |hit_flag))
                begin
                    // write verify or read failed on media or a flag
                    next_s.error[ERR_UNC_BIT] = 1'b1;
                    next_s.result = s.cur_lba;
                    next_s.busy   = 1'b0;
                    next_s.phase  = ST_IDLE;
                    events = 2'b11;
                end
                else if (s.op == OP_READ && |hit_pseudo)
                    next_s.phase = ST_RECOVER;
                if (next_s.phase == ST_SCAN && !next_s.nv_wr
                    && !(s.op == OP_WRITE && (|hit_flag || |hit_pseudo)))
                begin
                    next_s.cur_lba   = s.cur_lba + 48'h1;
                    next_s.remaining = s.remaining - 17'h1;
                end
                if ((s.op == OP_PSEUDO || s.op == OP_FLAGGED) && next_s.nv_wr)
                begin
                    next_s.cur_lba   = s.cur_lba + 48'h1;
                    next_s.remaining = s.remaining - 17'h1;
                end
                if (next_s.phase == ST_SCAN
                    && next_s.remaining == 17'h00000)
                begin
                    next_s.busy  = 1'b0;
                    next_s.phase = ST_IDLE;
                    events[IRQ_DONE_BIT] = 1'b1;
                end
            end
            ST_RECOVER:
            begin
                // full retry effort is spent before the sector is given up
                next_s.recover = s.recover - 16'h0001;
                if (s.recover == 16'h0001)
                begin
                    next_s.error[ERR_UNC_BIT] = 1'b1;
                    next_s.result = s.cur_lba;
                    next_s.busy   = 1'b0;
                    next_s.phase  = ST_IDLE;
                    events = 2'b11;
                end
            end
        endcase

        // read clears only the bits it reported; later events survive
        if (access && !req.pwrite && req.paddr == OFS_IRQ_STATUS)
            next_s.irq_status = s.irq_status & ~s.prdata[1:0];
        next_s.irq_status = next_s.irq_status | events;
        next_s.irq = |(next_s.irq_status & next_s.irq_mask);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            s <= '0;
        else
            s <= next_s;
    end

    assign prdata   = s.prdata;
    assign pready   = s.pready;
    assign pslverr  = s.pslverr;
    assign irq      = s.irq;
    assign nv_wr    = s.nv_wr;
    assign nv_index = s.nv_index;
    assign nv_entry = s.nv_entry;

endmodule

`default_nettype wire

//--- write_uncorrectable_cmd_assertions.sv
/*
 * Port-level checker for the write-uncorrectable command block.
 * Assumes one clock domain and the offsets of the shared package.
 */
`default_nettype none

module write_uncorrectable_cmd_checker
    import write_uncorrectable_pkg::*;
(
    input wire logic        clk,     // block clock
    input wire logic        rstn,    // async reset, low
    input wire logic        psel,    // apb select
    input wire logic        penable, // apb enable
    input wire logic        pwrite,  // apb direction
    input wire logic [7:0]  paddr,   // apb address
    input wire logic [31:0] prdata,  // apb read data
    input wire logic        pready,  // apb ready
    input wire logic        pslverr  // apb error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence rd_s(logic [7:0] a);
        setup_s ##0 (!pwrite && paddr == a);
    endsequence

    ready_next_a: assert property (setup_s |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    unmapped_err_a: assert property (setup_s ##0 (paddr > OFS_IRQ_MASK)
        |=> pslverr) else $error("unmapped address not refused");
    mapped_ok_a: assert property (setup_s ##0 (paddr <= OFS_IRQ_MASK
        && paddr[1:0] == 2'h0) |=> !pslverr)
        else $error("mapped address refused");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("refused access carries data");
    status_fixed_a: assert property (rd_s(OFS_STATUS) |=>
        prdata[31:8] == 24'h0 && prdata[6] && prdata[4]
        && !prdata[5] && !prdata[2]) else $error("status fixed bits wrong");
    error_bits_a: assert property (rd_s(OFS_ERROR) |=>
        (prdata & 32'hFFFF_FFAB) == 32'h0)
        else $error("undefined error bit set");
    field_width_a: assert property (rd_s(OFS_COUNT) |=>
        prdata[31:16] == 16'h0) else $error("count wider than 16 bits");
endmodule

bind write_uncorrectable_cmd write_uncorrectable_cmd_checker u_checker (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
);

`default_nettype wire

//--- nv_store_model.sv
/*
 * Behavioural nonvolatile mark store behind the nv_* outputs.
 * Assumes one save pulse per sector marked or mark cleared, on the block clock.
 */
`default_nettype none

module nv_store_model
    import write_uncorrectable_pkg::*;
#(
    parameter int ENTRIES = 8
)(
    input wire logic                         clk,      // block clock
    input wire logic                         nv_wr,    // save pulse
    input wire logic [$clog2(ENTRIES)-1:0]   nv_index, // slot
    input wire write_uncorrectable_pkg::mark_type nv_entry // record
);
    timeunit 1ns;
    timeprecision 1ps;
    mark_type slots [ENTRIES];

    initial
    begin
        foreach (slots[i]) slots[i] = '0;
    end

    // kept across resets on purpose: power loss must not wipe marks
    always @(posedge clk)
    begin
        if (nv_wr === 1'b1) slots[nv_index] <= nv_entry;
    end
endmodule

`default_nettype wire

//--- write_uncorrectable_cmd_bench.sv
/*
 * Self-checking bench: APB register accesses drive whole commands.
 * Assumes the package's register map; waits for pready, bounded.
 */
`default_nettype none

module write_uncorrectable_cmd_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import write_uncorrectable_pkg::*;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        media_err = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdata;
    logic        pready, pslverr, rerr, irq, nv_wr;
    logic [2:0]  nv_index;
    mark_type    nv_entry;
    int          n_errors = 0, n_checks = 0;
    logic [7:0]  rd_ops [12] = '{8'hC8, 8'h25, 8'hC4, 8'h29, 8'h20, 8'h21,
                                 8'h24, 8'h40, 8'h41, 8'h42, 8'h2A, 8'h2B};
    logic [7:0]  bad_ft [4] = '{8'h00, 8'h56, 8'hAB, 8'hFF};

    always #10 clk = ~clk;

    write_uncorrectable_cmd #(
        .MAX_LBA(48'h0000_00FF_FFFF)
    ) u_write_uncorrectable_cmd (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .media_err(media_err),
        .irq(irq), .nv_wr(nv_wr), .nv_index(nv_index), .nv_entry(nv_entry));
    nv_store_model u_nv_store_model (.clk(clk), .nv_wr(nv_wr),
        .nv_index(nv_index), .nv_entry(nv_entry));

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until ready seen; answer taken at the same edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            n_errors++;
            stop_test();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run_cmd(input logic [7:0] ft, input logic [15:0] cnt,
                           input logic [47:0] lba, input logic [7:0] op);
        int n;
        n = 0;
        apb(1, OFS_FEATURE, {24'h0, ft});
        apb(1, OFS_COUNT, {16'h0, cnt});
        apb(1, OFS_LBA_LOW, {8'h0, lba[23:0]});
        apb(1, OFS_LBA_HIGH, {8'h0, lba[47:24]});
        apb(1, OFS_COMMAND, {24'h0, op});
        apb(0, OFS_STATUS, 32'h0);
        while (rdata[STS_BSY_BIT] !== 1'b0 && n < 30000)
        begin
            apb(0, OFS_STATUS, 32'h0);
            n++;
        end
        if (n >= 30000)
        begin
            n_errors++;
            stop_test();
        end
    endtask

    task automatic expect_done(input logic [7:0] err, input logic [47:0] at);
        check(rdata, err == 8'h0 ? 32'h50 : 32'h51);
        apb(0, OFS_ERROR, 32'h0);
        check(rdata, {24'h0, err});
        if (err != 8'h0)
        begin
            apb(0, OFS_RESULT, 32'h0);
            check(rdata, {8'h0, at[23:0]});
        end
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        apb(0, OFS_STATUS, 32'h0);
        check(rdata, 32'h50);
        apb(0, 8'h2C, 32'h0);
        check({rerr, rdata}, 33'h1_0000_0000);
        check(irq, 1'b0);
        $display("test reset done");

        run_cmd(OPT_FLAGGED, 16'h1, 48'h5, CMD_WRITE_UNC);
        expect_done(8'h0, 48'h0);
        check(u_nv_store_model.slots[0], {2'b10, 48'h5});
        check(irq, 1'b0);
        apb(1, OFS_IRQ_MASK, 32'h3);
        apb(0, OFS_IRQ_MASK, 32'h0);
        check(rdata, 32'h3);
        check(irq, 1'b1);
        apb(0, OFS_IRQ_STATUS, 32'h0);
        check(rdata, 32'h1);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        $display("test flagged mark done");

        foreach (rd_ops[i])
        begin
            run_cmd(8'h0, 16'h3, 48'h4, rd_ops[i]);
            expect_done(8'h40, 48'h5);
        end
        $display("test read opcodes done");

        run_cmd(OPT_PSEUDO, 16'h1, 48'h13, CMD_WRITE_UNC);
        expect_done(8'h0, 48'h0);
        run_cmd(8'h0, 16'h1, 48'h17, 8'h20);
        expect_done(8'h40, 48'h17);
        run_cmd(8'h0, 16'h1, 48'h18, 8'h20);
        expect_done(8'h0, 48'h0);
        $display("test pseudo mark done");

        foreach (bad_ft[i])
        begin
            run_cmd(bad_ft[i], 16'h1, 48'h40, CMD_WRITE_UNC);
            expect_done(8'h04, 48'h0);
        end
        run_cmd(OPT_FLAGGED, 16'h1, 48'h40, 8'h46);
        expect_done(8'h04, 48'h0);
        $display("test abort done");

        run_cmd(8'h0, 16'h1, 48'h5, 8'h30);
        expect_done(8'h0, 48'h0);
        foreach (u_nv_store_model.slots[i])
            check(u_nv_store_model.slots[i] == {2'b10, 48'h5},
                  1'b0);
        run_cmd(8'h0, 16'h1, 48'h5, 8'h20);
        expect_done(8'h0, 48'h0);
        media_err <= 1'b1;
        run_cmd(8'h0, 16'h1, 48'h200, 8'h20);
        expect_done(8'h40, 48'h200);
        media_err <= 1'b0;
        $display("test write and media done");

        run_cmd(OPT_FLAGGED, 16'h2, 48'hFF_FFFF, CMD_WRITE_UNC);
        expect_done(8'h10, 48'h100_0000);
        apb(1, OFS_CONTROL, 32'h1);
        apb(0, OFS_RESULT, 32'h0);
        check(rdata, 32'h1);
        apb(1, OFS_CONTROL, 32'h0);
        $display("test address range done");

        run_cmd(OPT_FLAGGED, 16'h1, 48'h1_0FFF, CMD_WRITE_UNC);
        run_cmd(8'h0, 16'h0, 48'h1000, 8'h20);
        expect_done(8'h40, 48'h1_0FFF);
        apb(0, OFS_COUNT, 32'h0);
        check(rdata, 32'h0);
        $display("test zero count done");
        stop_test();
    end
endmodule

`default_nettype wire
